/* File: src/fttia_cfg.v */
`timescale 1ns/1ps
`include "fttia_defs.vh"

module fttia_cfg (
  // clock and reset
  input  wire        clk_i,
  input  wire        rst_b_i,
  // register port
  input  wire        wr_en_i,
  input  wire        rd_en_i,
  input  wire [15:0] addr_i,
  input  wire [31:0] wdata_i,
  output reg  [31:0] rdata_o,
  // tia controls
  output wire        tia_enable_o,
  output wire [2:0]  inv_in_sel_o,
  output wire        adc_sel_tia_o,
  output wire        cm_bias_o,
  output wire        cm_vzero_o,
  output wire [3:0]  gain_cfg_o,
  // drive-pin resistor switches
  output wire        drv_res_connect_o,
  output wire        drv_res_short_o,
  output wire [2:0]  drv_load_sel_o,
  output wire [3:0]  drv_gain_sel_o,
  // fast dac offset
  output wire [11:0] dac_offset_o,
  output wire        dac_offset_active_o
);

  ////////////////////////////////////////////////////////////////////////////
  // registers

  reg [31:0] fe_ctrl_q;
  reg [31:0] dac_ctrl_q;
  reg [3:0]  route_q;
  reg [3:0]  gain_cfg_q;
  reg [7:0]  drv_sel_q;
  reg [1:0]  tia_cfg_q;
  reg [11:0] ofs_q;
  reg        lock_q;

  function hit;
    input [15:0] a;
    input [15:0] r;
    begin
      hit = (a == r);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // write strobes, one per mapped register

  wire wr_fe_ctrl  = wr_en_i & hit(addr_i, `FTTIA_ADDR_FE_CTRL);
  wire wr_dac_ctrl = wr_en_i & hit(addr_i, `FTTIA_ADDR_DAC_CTRL);
  wire wr_route    = wr_en_i & hit(addr_i, `FTTIA_ADDR_ROUTE);
  wire wr_gain_cfg = wr_en_i & hit(addr_i, `FTTIA_ADDR_GAIN_CFG);
  wire wr_drv_sel  = wr_en_i & hit(addr_i, `FTTIA_ADDR_DRV_SEL);
  wire wr_tia_cfg  = wr_en_i & hit(addr_i, `FTTIA_ADDR_TIA_CFG);
  wire wr_cal_lock = wr_en_i & hit(addr_i, `FTTIA_ADDR_CAL_LOCK);
  // calibration data frozen while the lock is engaged
  wire wr_ofs      = wr_en_i & hit(addr_i, `FTTIA_ADDR_OFS_NOATT) & ~lock_q;

  // front-end control, bit 11 powers the tia
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      fe_ctrl_q <= `FTTIA_RST_ZERO32;
    end else if (wr_fe_ctrl) begin
      fe_ctrl_q <= wdata_i;
    end
  end

  // fast dac control, bit 12 is the attenuator
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      dac_ctrl_q <= `FTTIA_RST_ZERO32;
    end else if (wr_dac_ctrl) begin
      dac_ctrl_q <= wdata_i;
    end
  end

  // inverting input select plus adc mux bit
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      route_q <= `FTTIA_RST_ROUTE;
    end else if (wr_route) begin
      route_q <= wdata_i[`FTTIA_ROUTE_ADC_BIT:0];
    end
  end

  // only the low nibble of the gain config is kept
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      gain_cfg_q <= `FTTIA_RST_GAIN_CFG;
    end else if (wr_gain_cfg) begin
      gain_cfg_q <= wdata_i[`FTTIA_GAIN_MSB:0];
    end
  end

  // code kept as written; unlisted codes other than the short code decode to open
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      drv_sel_q <= `FTTIA_RST_DRV_SEL;
    end else if (wr_drv_sel) begin
      drv_sel_q <= wdata_i[`FTTIA_DRV_MSB:0];
    end
  end

  // reserved common-mode codes are stored but select nothing
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      tia_cfg_q <= `FTTIA_CM_BIAS;
    end else if (wr_tia_cfg) begin
      tia_cfg_q <= wdata_i[`FTTIA_CM_MSB:0];
    end
  end

  // lock stays writable so software can release it
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      lock_q <= `FTTIA_RST_UNLOCKED;
    end else if (wr_cal_lock) begin
      lock_q <= wdata_i[`FTTIA_LOCK_BIT];
    end
  end

  // reserved upper bits dropped on write
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ofs_q <= `FTTIA_RST_ZERO12;
    end else if (wr_ofs) begin
      ofs_q <= wdata_i[`FTTIA_OFS_MSB:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read path, unmapped reads zero

  reg [31:0] rdata_d;

  always @* begin
    case (addr_i)
      `FTTIA_ADDR_FE_CTRL:   rdata_d = fe_ctrl_q;
      `FTTIA_ADDR_DAC_CTRL:  rdata_d = dac_ctrl_q;
      `FTTIA_ADDR_ROUTE:     rdata_d = {28'h0, route_q};
      `FTTIA_ADDR_GAIN_CFG:  rdata_d = {28'h0, gain_cfg_q};
      `FTTIA_ADDR_DRV_SEL:   rdata_d = {24'h0, drv_sel_q};
      `FTTIA_ADDR_TIA_CFG:   rdata_d = {30'h0, tia_cfg_q};
      `FTTIA_ADDR_CAL_LOCK:  rdata_d = {31'h0, lock_q};
      `FTTIA_ADDR_OFS_NOATT: rdata_d = {20'h0, ofs_q};
      default:               rdata_d = `FTTIA_RST_ZERO32;
    endcase
  end

  // read data held until the next read strobe
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rdata_o <= `FTTIA_RST_ZERO32;
    end else if (rd_en_i) begin
      rdata_o <= rdata_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // decoded controls

  assign tia_enable_o  = fe_ctrl_q[`FTTIA_FE_TIA_EN_BIT];
  assign inv_in_sel_o  = route_q[`FTTIA_ROUTE_MSB:0];
  assign adc_sel_tia_o = route_q[`FTTIA_ROUTE_ADC_BIT];
  // reserved codes select neither source
  assign cm_bias_o     = (tia_cfg_q == `FTTIA_CM_BIAS);
  assign cm_vzero_o    = (tia_cfg_q == `FTTIA_CM_VZERO);
  assign gain_cfg_o    = gain_cfg_q;

  // offset passes through as two's complement, zero while attenuator on
  assign dac_offset_active_o = !dac_ctrl_q[`FTTIA_DAC_ATTEN_BIT];
  assign dac_offset_o        = dac_offset_active_o ? ofs_q : `FTTIA_RST_ZERO12;

  wire       dec_connect;
  wire       dec_short;
  wire [2:0] dec_load;
  wire [3:0] dec_gain;

  // decode is registered: switch outputs trail a code write by one cycle
  fttia_res_decode fttia_res_decode_i (
    .clk_i      (clk_i),
    .rst_b_i    (rst_b_i),
    .code_i     (drv_sel_q),
    .connect_o  (dec_connect),
    .short_o    (dec_short),
    .load_sel_o (dec_load),
    .gain_sel_o (dec_gain)
  );

  // drive-pin connect only asserts while that pin is routed in; short, load and gain are not gated
  wire drv_routed = (route_q[`FTTIA_ROUTE_MSB:0] == `FTTIA_IN_DRIVE);

  assign drv_res_connect_o = dec_connect & drv_routed;
  assign drv_res_short_o   = dec_short;
  assign drv_load_sel_o    = dec_load;
  assign drv_gain_sel_o    = dec_gain;

endmodule // fttia_cfg

/* File: src/fttia_defs.vh */
`ifndef FTTIA_DEFS_VH
`define FTTIA_DEFS_VH

// register byte addresses
`define FTTIA_ADDR_FE_CTRL     16'h2000
`define FTTIA_ADDR_DAC_CTRL    16'h2010
`define FTTIA_ADDR_ROUTE       16'h20f4
`define FTTIA_ADDR_GAIN_CFG    16'h20f0
`define FTTIA_ADDR_DRV_SEL     16'h20f8
`define FTTIA_ADDR_TIA_CFG     16'h20fc
`define FTTIA_ADDR_OFS_NOATT   16'h22bc
`define FTTIA_ADDR_CAL_LOCK    16'h2270

// reset values
`define FTTIA_RST_GAIN_CFG     4'hf
`define FTTIA_RST_DRV_SEL      8'hff
`define FTTIA_RST_ZERO12       12'h000
`define FTTIA_RST_ZERO32       32'h0000_0000
`define FTTIA_RST_ROUTE        4'h0
`define FTTIA_RST_UNLOCKED     1'h0

// field positions
`define FTTIA_FE_TIA_EN_BIT    11
`define FTTIA_DAC_ATTEN_BIT    12
`define FTTIA_ROUTE_ADC_BIT    3
`define FTTIA_OFS_MSB          11
`define FTTIA_CM_MSB           1
`define FTTIA_ROUTE_MSB        2
`define FTTIA_GAIN_MSB         3
`define FTTIA_DRV_MSB          7
`define FTTIA_LOCK_BIT         0

// common-mode source codes
`define FTTIA_CM_BIAS          2'h0
`define FTTIA_CM_VZERO         2'h1

// drive-pin special codes
`define FTTIA_DRV_OPEN         8'hff
`define FTTIA_DRV_SHORT        8'h97

// inverting input route codes
`define FTTIA_IN_SENSE         3'h0
`define FTTIA_IN_AIN3          3'h4
`define FTTIA_IN_DRIVE         3'h5

`endif

/* File: src/fttia_res_decode.v */
`timescale 1ns/1ps
`include "fttia_defs.vh"

module fttia_res_decode (
  // clock and reset
  input  wire       clk_i,
  input  wire       rst_b_i,
  // select code
  input  wire [7:0] code_i,
  // switch controls
  output reg        connect_o,
  output reg        short_o,
  output reg  [2:0] load_sel_o,
  output reg  [3:0] gain_sel_o
);

  // {valid, load index, gain index}; load 0..4 = 0,10,30,50,100 ohm
  function [7:0] dec;
    input [7:0] c;
    begin
      case (c)
        8'h00: dec = {1'b1, 3'h0, 4'h0};
        8'h18: dec = {1'b1, 3'h0, 4'h1};
        8'h38: dec = {1'b1, 3'h0, 4'h2};
        8'h58: dec = {1'b1, 3'h0, 4'h3};
        8'h60: dec = {1'b1, 3'h0, 4'h4};
        8'h68: dec = {1'b1, 3'h0, 4'h5};
        8'h70: dec = {1'b1, 3'h0, 4'h6};
        8'h78: dec = {1'b1, 3'h0, 4'h7};
        8'h80: dec = {1'b1, 3'h0, 4'h8};
        8'h88: dec = {1'b1, 3'h0, 4'h9};
        8'h09: dec = {1'b1, 3'h1, 4'h0};
        8'h21: dec = {1'b1, 3'h1, 4'h1};
        8'h39: dec = {1'b1, 3'h1, 4'h2};
        8'h59: dec = {1'b1, 3'h1, 4'h3};
        8'h61: dec = {1'b1, 3'h1, 4'h4};
        8'h69: dec = {1'b1, 3'h1, 4'h5};
        8'h71: dec = {1'b1, 3'h1, 4'h6};
        8'h79: dec = {1'b1, 3'h1, 4'h7};
        8'h81: dec = {1'b1, 3'h1, 4'h8};
        8'h89: dec = {1'b1, 3'h1, 4'h9};
        8'h12: dec = {1'b1, 3'h2, 4'h0};
        8'h2a: dec = {1'b1, 3'h2, 4'h1};
        8'h4a: dec = {1'b1, 3'h2, 4'h2};
        8'h5a: dec = {1'b1, 3'h2, 4'h3};
        8'h62: dec = {1'b1, 3'h2, 4'h4};
        8'h6a: dec = {1'b1, 3'h2, 4'h5};
        8'h72: dec = {1'b1, 3'h2, 4'h6};
        8'h7a: dec = {1'b1, 3'h2, 4'h7};
        8'h82: dec = {1'b1, 3'h2, 4'h8};
        8'h8a: dec = {1'b1, 3'h2, 4'h9};
        8'h1b: dec = {1'b1, 3'h3, 4'h0};
        8'h33: dec = {1'b1, 3'h3, 4'h1};
        8'h4b: dec = {1'b1, 3'h3, 4'h2};
        8'h5b: dec = {1'b1, 3'h3, 4'h3};
        8'h63: dec = {1'b1, 3'h3, 4'h4};
        8'h6b: dec = {1'b1, 3'h3, 4'h5};
        8'h73: dec = {1'b1, 3'h3, 4'h6};
        8'h7b: dec = {1'b1, 3'h3, 4'h7};
        8'h83: dec = {1'b1, 3'h3, 4'h8};
        8'h8b: dec = {1'b1, 3'h3, 4'h9};
        8'h34: dec = {1'b1, 3'h4, 4'h0};
        8'h3c: dec = {1'b1, 3'h4, 4'h1};
        8'h54: dec = {1'b1, 3'h4, 4'h2};
        8'h5c: dec = {1'b1, 3'h4, 4'h3};
        8'h64: dec = {1'b1, 3'h4, 4'h4};
        8'h6c: dec = {1'b1, 3'h4, 4'h5};
        8'h74: dec = {1'b1, 3'h4, 4'h6};
        8'h7c: dec = {1'b1, 3'h4, 4'h7};
        8'h84: dec = {1'b1, 3'h4, 4'h8};
        8'h8c: dec = {1'b1, 3'h4, 4'h9};
        default: dec = 8'h00;
      endcase
    end
  endfunction

  wire [7:0] d = dec(code_i);

  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      connect_o  <= 1'b0;
      short_o    <= 1'b0;
      load_sel_o <= 3'h0;
      gain_sel_o <= 4'h0;
    end else begin
      short_o    <= (code_i == `FTTIA_DRV_SHORT);
      connect_o  <= d[7];
      load_sel_o <= d[6:4];
      gain_sel_o <= d[3:0];
    end
  end

endmodule // fttia_res_decode

/* File: verif/fttia_cfg_sva.sv */
`timescale 1ns/1ps
`include "fttia_defs.vh"

module fttia_cfg_chk (
  // clock and reset
  input wire        clk_i,
  input wire        rst_b_i,
  // register port
  input wire        wr_en_i,
  input wire        rd_en_i,
  input wire [15:0] addr_i,
  input wire [31:0] wdata_i,
  input wire [31:0] rdata_o,
  // tia controls
  input wire        tia_enable_o,
  input wire [2:0]  inv_in_sel_o,
  input wire        adc_sel_tia_o,
  input wire        cm_bias_o,
  input wire        cm_vzero_o,
  input wire [3:0]  gain_cfg_o,
  // drive-pin switches and offset
  input wire        drv_res_connect_o,
  input wire        drv_res_short_o,
  input wire [2:0]  drv_load_sel_o,
  input wire [3:0]  drv_gain_sel_o,
  input wire [11:0] dac_offset_o,
  input wire        dac_offset_active_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  wire wr_drv = wr_en_i && addr_i == `FTTIA_ADDR_DRV_SEL;
  reg  lock_m;
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) lock_m <= 1'b0;
    else if (wr_en_i && addr_i == `FTTIA_ADDR_CAL_LOCK) lock_m <= wdata_i[0];
  end
  ////////////////////////////////////////////////////////////////////////
  chk_offset_gate: assert property (!dac_offset_active_o |-> dac_offset_o == 12'h000)
    else $error("offset passed while attenuator on");
  chk_atten_bit: assert property (wr_en_i && addr_i == `FTTIA_ADDR_DAC_CTRL |=>
    dac_offset_active_o == !$past(wdata_i[12]))
    else $error("offset active does not follow attenuator bit");
  chk_ofs_upper: assert property (rd_en_i && addr_i == `FTTIA_ADDR_OFS_NOATT |=> rdata_o[31:12] == 20'h00000)
    else $error("offset upper bits not zero");
  chk_tia_enable: assert property (wr_en_i && addr_i == `FTTIA_ADDR_FE_CTRL |=> tia_enable_o == $past(wdata_i[11]))
    else $error("tia enable does not follow bit 11");
  chk_cm_exclusive: assert property (!(cm_bias_o && cm_vzero_o))
    else $error("both common-mode sources on");
  chk_cm_bias_sel: assert property (wr_en_i && addr_i == `FTTIA_ADDR_TIA_CFG && wdata_i[1:0] == 2'h0 |=>
    cm_bias_o && !cm_vzero_o)
    else $error("bias source not selected");
  chk_route_sel: assert property (wr_en_i && addr_i == `FTTIA_ADDR_ROUTE |=>
    inv_in_sel_o == $past(wdata_i[2:0]) && adc_sel_tia_o == $past(wdata_i[3]))
    else $error("route outputs wrong");
  chk_short_code: assert property (wr_drv && wdata_i[7:0] == 8'h97 |=> ##1 drv_res_short_o && !drv_res_connect_o)
    else $error("short code not decoded");
  chk_open_code: assert property (wr_drv && wdata_i[7:0] == 8'hff |=> ##1 !drv_res_short_o && !drv_res_connect_o)
    else $error("open code not decoded");
  chk_gain_range: assert property (wr_drv && wdata_i[7:0] == 8'h8b |=> ##1
    drv_load_sel_o == 3'h3 && drv_gain_sel_o == 4'h9)
    else $error("top of 50 ohm range not decoded");
  chk_lock_block: assert property (wr_en_i && addr_i == `FTTIA_ADDR_OFS_NOATT && lock_m |=> $stable(dac_offset_o))
    else $error("offset written while locked");
  chk_gain_cfg: assert property (wr_en_i && addr_i == `FTTIA_ADDR_GAIN_CFG |=> gain_cfg_o == $past(wdata_i[3:0]))
    else $error("gain config not stored");
  cov_short: cover property (drv_res_short_o);
  cov_connect: cover property (drv_res_connect_o && drv_load_sel_o == 3'h4);
  cov_atten: cover property (!dac_offset_active_o);
endmodule // fttia_cfg_chk

bind fttia_cfg fttia_cfg_chk fttia_cfg_chk_i (.clk_i(clk_i), .rst_b_i(rst_b_i), .wr_en_i(wr_en_i),
  .rd_en_i(rd_en_i), .addr_i(addr_i), .wdata_i(wdata_i), .rdata_o(rdata_o), .tia_enable_o(tia_enable_o),
  .inv_in_sel_o(inv_in_sel_o), .adc_sel_tia_o(adc_sel_tia_o), .cm_bias_o(cm_bias_o), .cm_vzero_o(cm_vzero_o),
  .gain_cfg_o(gain_cfg_o), .drv_res_connect_o(drv_res_connect_o), .drv_res_short_o(drv_res_short_o),
  .drv_load_sel_o(drv_load_sel_o), .drv_gain_sel_o(drv_gain_sel_o), .dac_offset_o(dac_offset_o),
  .dac_offset_active_o(dac_offset_active_o));

/* File: verif/fttia_cfg_tb.sv */
`timescale 1ns/1ps
`include "fttia_defs.vh"

module fttia_cfg_tb;
  logic        clk_i, rst_b_i, wr_en_i, rd_en_i;
  logic [15:0] addr_i;
  logic [31:0] wdata_i, rdata_o, rd_q;
  logic        tia_enable_o, adc_sel_tia_o, cm_bias_o, cm_vzero_o;
  logic        drv_res_connect_o, drv_res_short_o, dac_offset_active_o;
  logic [2:0]  inv_in_sel_o, drv_load_sel_o;
  logic [3:0]  gain_cfg_o, drv_gain_sel_o;
  logic [11:0] dac_offset_o;
  int          err_total, n_tests;
  logic [7:0]  drv_tbl [0:49] = '{8'h00, 8'h18, 8'h38, 8'h58, 8'h60, 8'h68, 8'h70, 8'h78, 8'h80, 8'h88,
    8'h09, 8'h21, 8'h39, 8'h59, 8'h61, 8'h69, 8'h71, 8'h79, 8'h81, 8'h89,
    8'h12, 8'h2a, 8'h4a, 8'h5a, 8'h62, 8'h6a, 8'h72, 8'h7a, 8'h82, 8'h8a,
    8'h1b, 8'h33, 8'h4b, 8'h5b, 8'h63, 8'h6b, 8'h73, 8'h7b, 8'h83, 8'h8b,
    8'h34, 8'h3c, 8'h54, 8'h5c, 8'h64, 8'h6c, 8'h74, 8'h7c, 8'h84, 8'h8c};
  logic [11:0] ofs_tbl [0:4] = '{12'h7ff, 12'h001, 12'h000, 12'hfff, 12'h800};

  fttia_cfg fttia_cfg_i (.clk_i(clk_i), .rst_b_i(rst_b_i), .wr_en_i(wr_en_i), .rd_en_i(rd_en_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .rdata_o(rdata_o), .tia_enable_o(tia_enable_o),
    .inv_in_sel_o(inv_in_sel_o), .adc_sel_tia_o(adc_sel_tia_o), .cm_bias_o(cm_bias_o),
    .cm_vzero_o(cm_vzero_o), .gain_cfg_o(gain_cfg_o), .drv_res_connect_o(drv_res_connect_o),
    .drv_res_short_o(drv_res_short_o), .drv_load_sel_o(drv_load_sel_o), .drv_gain_sel_o(drv_gain_sel_o),
    .dac_offset_o(dac_offset_o), .dac_offset_active_o(dac_offset_active_o));
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    @(negedge clk_i);
    wr_en_i = 1'b1; addr_i = a; wdata_i = d;
    @(negedge clk_i);
    wr_en_i = 1'b0;
  endtask
  task automatic rd(input logic [15:0] a);
    @(negedge clk_i);
    rd_en_i = 1'b1; addr_i = a;
    @(negedge clk_i);
    rd_en_i = 1'b0; rd_q = rdata_o;
  endtask
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    chk("tia_enable", 0, tia_enable_o);
    chk("cm_bias", 1, cm_bias_o);
    rd(`FTTIA_ADDR_DRV_SEL); chk("drv reset", 32'h0000_00ff, rd_q);
    rd(`FTTIA_ADDR_OFS_NOATT); chk("ofs reset", 32'h0, rd_q);
    rd(`FTTIA_ADDR_TIA_CFG); chk("tia cfg reset", 32'h0, rd_q);
    rd(`FTTIA_ADDR_GAIN_CFG); chk("gain reset", 32'h0000_000f, rd_q);
    rd(16'h2004); chk("unmapped", 32'h0, rd_q);
    $display("done reset");
  endtask
  task automatic t_offset;
    for (int i = 0; i < 5; i++) begin
      wr(`FTTIA_ADDR_OFS_NOATT, {20'hfffff, ofs_tbl[i]});
      chk("ofs out", ofs_tbl[i], dac_offset_o);
      rd(`FTTIA_ADDR_OFS_NOATT); chk("ofs read", {20'h0, ofs_tbl[i]}, rd_q);
    end
    wr(`FTTIA_ADDR_DAC_CTRL, 32'h0000_1000);
    chk("ofs gated", 0, dac_offset_o); chk("ofs active", 0, dac_offset_active_o);
    wr(`FTTIA_ADDR_DAC_CTRL, 32'h0);
    chk("ofs back", 32'h800, dac_offset_o);
    wr(`FTTIA_ADDR_CAL_LOCK, 32'h1); wr(`FTTIA_ADDR_OFS_NOATT, 32'h123);
    rd(`FTTIA_ADDR_OFS_NOATT); chk("ofs locked", 32'h800, rd_q);
    wr(`FTTIA_ADDR_CAL_LOCK, 32'h0); wr(`FTTIA_ADDR_OFS_NOATT, 32'h123);
    rd(`FTTIA_ADDR_OFS_NOATT); chk("ofs unlocked", 32'h123, rd_q);
    $display("done offset");
  endtask
  task automatic t_front;
    wr(`FTTIA_ADDR_FE_CTRL, 32'h0000_0800); chk("tia on", 1, tia_enable_o);
    for (int k = 0; k < 4; k++) begin
      wr(`FTTIA_ADDR_TIA_CFG, k);
      chk("cm bias", k == 0, cm_bias_o); chk("cm vzero", k == 1, cm_vzero_o);
    end
    for (int r = 0; r < 6; r++) begin
      wr(`FTTIA_ADDR_ROUTE, r | ((r & 1) << 3));
      chk("route", r, inv_in_sel_o); chk("adc sel", r & 1, adc_sel_tia_o);
    end
    $display("done front");
  endtask
  task automatic t_drive;
    for (int i = 0; i < 50; i++) begin
      wr(`FTTIA_ADDR_DRV_SEL, drv_tbl[i]); @(negedge clk_i);
      chk("connect", 1, drv_res_connect_o); chk("load", i / 10, drv_load_sel_o);
      chk("gain", i % 10, drv_gain_sel_o);
    end
    wr(`FTTIA_ADDR_DRV_SEL, 32'h01); @(negedge clk_i);
    chk("unlisted", 0, {drv_res_connect_o, drv_load_sel_o, drv_gain_sel_o});
    rd(`FTTIA_ADDR_DRV_SEL); chk("unlisted read", 32'h01, rd_q);
    wr(`FTTIA_ADDR_DRV_SEL, 32'h97); wr(`FTTIA_ADDR_GAIN_CFG, 32'h0f);
    chk("short", 1, drv_res_short_o); chk("gain cfg", 4'hf, gain_cfg_o);
    wr(`FTTIA_ADDR_DRV_SEL, 32'hff); @(negedge clk_i);
    chk("open", 0, {drv_res_connect_o, drv_res_short_o});
    wr(`FTTIA_ADDR_DRV_SEL, 32'h97); wr(`FTTIA_ADDR_ROUTE, `FTTIA_IN_AIN3);
    chk("ext short", 1, drv_res_short_o); chk("ext input", `FTTIA_IN_AIN3, inv_in_sel_o);
    wr(`FTTIA_ADDR_DRV_SEL, 32'h8c); @(negedge clk_i);
    chk("unrouted", 32'h49, {drv_res_connect_o, drv_load_sel_o, drv_gain_sel_o});
    $display("done drive");
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  initial begin
    repeat (5000) @(posedge clk_i);
    err_total++;
    close_out;
  end
  initial begin
    rst_b_i = 1'b0; wr_en_i = 1'b0; rd_en_i = 1'b0; addr_i = 16'h0000; wdata_i = 32'h0;
    err_total = 0; n_tests = 0;
    repeat (20) @(negedge clk_i);
    rst_b_i = 1'b1;
    t_reset;
    t_offset;
    t_front;
    t_drive;
    close_out;
  end
endmodule // fttia_cfg_tb
